// File: shared/rac_pkg.sv
package rac_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] RAC_OFF_SELECT = 8'h00;
	localparam logic [7:0] RAC_OFF_BASE = 8'h04;
	localparam logic [7:0] RAC_OFF_ATTR = 8'h08;
	localparam logic [7:0] RAC_OFF_CAUSE = 8'h0c;
	localparam logic [7:0] RAC_OFF_FADDR = 8'h10;
	localparam logic [7:0] RAC_OFF_CTRL = 8'h14;

	// region attribute register fields
	localparam int RAC_ATTR_XN_BIT = 28;
	localparam int RAC_ATTR_AP_LSB = 24;
	localparam int RAC_ATTR_TEX_LSB = 19;
	localparam int RAC_ATTR_S_BIT = 18;
	localparam int RAC_ATTR_C_BIT = 17;
	localparam int RAC_ATTR_B_BIT = 16;
	localparam int RAC_ATTR_SIZE_LSB = 1;
	localparam int RAC_ATTR_EN_BIT = 0;
	localparam logic [31:0] RAC_ATTR_MASK = 32'h173fff3f;

	// region base register fields
	localparam int RAC_BASE_ADDR_LSB = 5;
	localparam int RAC_BASE_VALID_BIT = 4;

	// fault cause and control fields
	localparam int RAC_CAUSE_FETCH_BIT = 0;
	localparam int RAC_CAUSE_DATA_BIT = 1;
	localparam int RAC_CAUSE_ADDR_VALID_BIT = 7;
	localparam logic [31:0] RAC_CAUSE_MASK = 32'h00000083;
	localparam int RAC_CTRL_EN_BIT = 0;
	localparam int RAC_CTRL_PRIVDEF_BIT = 2;
	localparam logic [31:0] RAC_CTRL_MASK = 32'h00000005;

	// reset values
	localparam logic [31:0] RAC_RST_WORD = 32'h00000000;
	localparam logic [3:0] RAC_RST_SEL = 4'h0;

	// size code: region bytes = 2^(code+1), so low address bits = code+1
	localparam logic [5:0] RAC_SIZE_TO_N = 6'h01;
	localparam logic [5:0] RAC_N_FULL = 6'h20;

	// permission codes
	localparam logic [2:0] RAC_AP_NONE = 3'h0;
	localparam logic [2:0] RAC_AP_PRIV_RW = 3'h1;
	localparam logic [2:0] RAC_AP_USER_RO = 3'h2;
	localparam logic [2:0] RAC_AP_FULL = 3'h3;
	localparam logic [2:0] RAC_AP_PRIV_RO = 3'h5;
	localparam logic [2:0] RAC_AP_RO_A = 3'h6;
	localparam logic [2:0] RAC_AP_RO_B = 3'h7;

	// cache policy codes
	localparam logic [1:0] RAC_POL_NC = 2'h0;
	localparam logic [1:0] RAC_POL_WB_RWA = 2'h1;

	// bus responses
	localparam logic [1:0] RAC_RESP_OKAY = 2'h0;
	localparam logic [1:0] RAC_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		RAC_ACC_READ = 2'b00,
		RAC_ACC_WRITE = 2'b01,
		RAC_ACC_FETCH = 2'b10
	} rac_acc_kind_t;

	typedef enum logic [2:0] {
		RAC_MT_STRONG = 3'b000,
		RAC_MT_DEVICE = 3'b001,
		RAC_MT_NORMAL = 3'b010,
		RAC_MT_RESERVED = 3'b011,
		RAC_MT_IMPDEF = 3'b100
	} rac_mem_type_t;

	typedef struct packed {
		rac_mem_type_t mem_type;
		logic shareable;
		logic [1:0] inner_policy;
		logic [1:0] outer_policy;
	} rac_attr_t;

	typedef struct packed {
		logic [31:0] addr;
		logic priv;
		rac_acc_kind_t kind;
	} rac_req_t;

	typedef struct packed {
		logic fault;
		logic hit;
		logic [3:0] region;
		rac_attr_t attr;
	} rac_resp_t;

	typedef struct packed {
		logic [26:0] base;
		logic [31:0] attr;
	} rac_region_t;

endpackage : rac_pkg

// File: design/rac_region_checker.sv
module rac_region_checker
	import rac_pkg::*;
#(
	parameter int NREG = 8
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	// register bus, axi4-lite slave
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	output logic [1:0] o_s_axi_bresp,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	input wire logic [7:0] i_s_axi_araddr,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	// access check port from the core
	input wire logic i_chk_valid,
	input wire rac_req_t i_chk_req,
	output logic o_chk_valid,
	output rac_resp_t o_chk_resp,
	output logic o_memory_management_fault
);

	typedef struct packed {
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [3:0] sel;
		logic [31:0] ctrl;
		logic [31:0] cause;
		logic [31:0] faddr;
		rac_region_t [NREG-1:0] regs;
		logic chk_valid;
		rac_resp_t chk_resp;
		logic mm_fault;
	} rac_state_t;

	rac_state_t state_ff;
	rac_state_t nxt_state;
	logic rst_meta_ff;
	logic rst_sync_ff;

	// byte-lane merge of a bus write into an old word
	function automatic logic [31:0] rac_merge(input logic [31:0] old_w, input logic [31:0] new_w,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int k = 0; k < 4; k++) begin
			if (strb[k]) begin
				res[k*8 +: 8] = new_w[k*8 +: 8];
			end
		end
		return res;
	endfunction : rac_merge

	// address falls in region when bits from size code plus one upward match
	function automatic logic rac_hit(input logic [31:0] addr, input logic [26:0] base,
			input logic [4:0] size);
		logic [5:0] n;
		logic [31:0] mask;
		n = {1'b0, size} + RAC_SIZE_TO_N;
		mask = (n >= RAC_N_FULL) ? 32'h00000000 : (32'hffffffff << n);
		return (((addr ^ {base, 5'h00}) & mask) == 32'h00000000);
	endfunction : rac_hit

	// memory type, shareability and cache policies from tex, c, b, s
	function automatic rac_attr_t rac_decode(input logic [2:0] type_extension_bits, input logic c, input logic b,
			input logic s);
		rac_attr_t a;
		a.mem_type = RAC_MT_RESERVED;
		a.shareable = 1'b0;
		a.inner_policy = RAC_POL_NC;
		a.outer_policy = RAC_POL_NC;
		if (type_extension_bits[2]) begin
			a.mem_type = RAC_MT_NORMAL;
			a.shareable = s;
			a.outer_policy = type_extension_bits[1:0];
			a.inner_policy = {c, b};
		end else begin
			case (type_extension_bits[1:0])
				2'b00: begin
					if (!c) begin
						a.mem_type = b ? RAC_MT_DEVICE : RAC_MT_STRONG;
						a.shareable = 1'b1;
					end else begin
						a.mem_type = RAC_MT_NORMAL;
						a.shareable = s;
						a.inner_policy = {c, b};
						a.outer_policy = {c, b};
					end
				end
				2'b01: begin
					case ({c, b})
						2'b00: begin
							a.mem_type = RAC_MT_NORMAL;
							a.shareable = s;
						end
						2'b11: begin
							a.mem_type = RAC_MT_NORMAL;
							a.shareable = s;
							a.inner_policy = RAC_POL_WB_RWA;
							a.outer_policy = RAC_POL_WB_RWA;
						end
						2'b10: begin
							a.mem_type = RAC_MT_IMPDEF;
						end
						default: begin
							a.mem_type = RAC_MT_RESERVED;
						end
					endcase
				end
				2'b10: begin
					if (!c && !b) begin
						a.mem_type = RAC_MT_DEVICE;
					end else begin
						a.mem_type = RAC_MT_RESERVED;
					end
				end
				default: begin
					a.mem_type = RAC_MT_RESERVED;
				end
			endcase
		end
		return a;
	endfunction : rac_decode

	// permission code against privilege and direction
	function automatic logic rac_perm_ok(input logic [2:0] ap, input logic priv,
			input logic wr);
		logic ok;
		case (ap)
			RAC_AP_NONE: ok = 1'b0;
			RAC_AP_PRIV_RW: ok = priv;
			RAC_AP_USER_RO: ok = priv | !wr;
			RAC_AP_FULL: ok = 1'b1;
			RAC_AP_PRIV_RO: ok = priv & !wr;
			RAC_AP_RO_A: ok = !wr;
			RAC_AP_RO_B: ok = !wr;
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : rac_perm_ok

	// reset release through two flops
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// next-state logic: bus slave, region lookup, fault capture
	always_comb begin
		logic [3:0] tgt;
		logic [31:0] word;
		logic [31:0] clr;
		logic [31:0] setv;
		logic hit;
		logic [3:0] idx;
		logic [31:0] attr;
		logic wr;
		logic fetch;
		logic fault;
		logic [31:0] mrg;
		tgt = 4'h0;
		mrg = 32'h00000000;
		word = 32'h00000000;
		clr = 32'h00000000;
		setv = 32'h00000000;
		hit = 1'b0;
		idx = 4'h0;
		attr = 32'h00000000;
		wr = 1'b0;
		fetch = 1'b0;
		fault = 1'b0;
		nxt_state = state_ff;

		// write address and data, taken in either order
		if (i_s_axi_awvalid && state_ff.awready) begin
			nxt_state.aw_have = 1'b1;
			nxt_state.aw_addr = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && state_ff.wready) begin
			nxt_state.w_have = 1'b1;
			nxt_state.w_data = i_s_axi_wdata;
			nxt_state.w_strb = i_s_axi_wstrb;
		end
		if (state_ff.bvalid && i_s_axi_bready) begin
			nxt_state.bvalid = 1'b0;
		end

		// perform the write once both halves are held
		if (state_ff.aw_have && state_ff.w_have && !state_ff.bvalid) begin
			nxt_state.aw_have = 1'b0;
			nxt_state.w_have = 1'b0;
			nxt_state.bvalid = 1'b1;
			nxt_state.bresp = RAC_RESP_OKAY;
			word = rac_merge(32'h00000000, state_ff.w_data, state_ff.w_strb);
			case ({state_ff.aw_addr[7:2], 2'b00})
				RAC_OFF_SELECT: begin
					if (state_ff.w_strb[0]) begin
						nxt_state.sel = state_ff.w_data[3:0];
					end
				end
				RAC_OFF_BASE: begin
					tgt = state_ff.w_data[RAC_BASE_VALID_BIT] ? state_ff.w_data[3:0] : state_ff.sel;
					if (state_ff.w_data[RAC_BASE_VALID_BIT]) begin
						nxt_state.sel = state_ff.w_data[3:0];
					end
					if (32'(tgt) < NREG) begin
						mrg = rac_merge({state_ff.regs[tgt].base, 5'h00}, state_ff.w_data,
							state_ff.w_strb);
						nxt_state.regs[tgt].base = mrg[31:RAC_BASE_ADDR_LSB];
					end
				end
				RAC_OFF_ATTR: begin
					if (32'(state_ff.sel) < NREG) begin
						nxt_state.regs[state_ff.sel].attr = rac_merge(state_ff.regs[state_ff.sel].attr,
							state_ff.w_data, state_ff.w_strb) & RAC_ATTR_MASK;
					end
				end
				RAC_OFF_CAUSE: clr = word & RAC_CAUSE_MASK; // write one to clear
				RAC_OFF_FADDR: nxt_state.bresp = RAC_RESP_OKAY; // read only, write ignored
				RAC_OFF_CTRL: begin
					nxt_state.ctrl = rac_merge(state_ff.ctrl, state_ff.w_data, state_ff.w_strb)
						& RAC_CTRL_MASK;
				end
				default: nxt_state.bresp = RAC_RESP_SLVERR;
			endcase
		end
		nxt_state.awready = !nxt_state.aw_have && !nxt_state.bvalid;
		nxt_state.wready = !nxt_state.w_have && !nxt_state.bvalid;

		// read channel: answer in the cycle after the address is taken
		if (state_ff.rvalid && i_s_axi_rready) begin
			nxt_state.rvalid = 1'b0;
			nxt_state.arready = 1'b1;
		end
		if (i_s_axi_arvalid && state_ff.arready) begin
			nxt_state.arready = 1'b0;
			nxt_state.rvalid = 1'b1;
			nxt_state.rresp = RAC_RESP_OKAY;
			nxt_state.rdata = 32'h00000000;
			case ({i_s_axi_araddr[7:2], 2'b00})
				RAC_OFF_SELECT: nxt_state.rdata = {28'h0000000, state_ff.sel};
				RAC_OFF_BASE: begin
					if (32'(state_ff.sel) < NREG) begin
						nxt_state.rdata = {state_ff.regs[state_ff.sel].base, 1'b0, state_ff.sel};
					end else begin
						nxt_state.rdata = {28'h0000000, state_ff.sel};
					end
				end
				RAC_OFF_ATTR: begin
					if (32'(state_ff.sel) < NREG) begin
						nxt_state.rdata = state_ff.regs[state_ff.sel].attr;
					end
				end
				RAC_OFF_CAUSE: nxt_state.rdata = state_ff.cause;
				RAC_OFF_FADDR: nxt_state.rdata = state_ff.faddr;
				RAC_OFF_CTRL: nxt_state.rdata = state_ff.ctrl;
				default: nxt_state.rresp = RAC_RESP_SLVERR;
			endcase
		end

		// region lookup: highest enabled matching region wins
		for (int i = 0; i < NREG; i++) begin
			if (state_ff.regs[i].attr[RAC_ATTR_EN_BIT] &&
					rac_hit(i_chk_req.addr, state_ff.regs[i].base,
					state_ff.regs[i].attr[RAC_ATTR_SIZE_LSB +: 5])) begin
				hit = 1'b1;
				idx = 4'(i);
			end
		end
		attr = state_ff.regs[idx].attr;
		wr = (i_chk_req.kind == RAC_ACC_WRITE);
		fetch = (i_chk_req.kind == RAC_ACC_FETCH);

		// permission and never-execute test, unit off passes everything
		if (state_ff.ctrl[RAC_CTRL_EN_BIT]) begin
			if (hit) begin
				fault = !rac_perm_ok(attr[RAC_ATTR_AP_LSB +: 3], i_chk_req.priv, wr)
					|| (fetch && attr[RAC_ATTR_XN_BIT]);
			end else begin
				fault = !(state_ff.ctrl[RAC_CTRL_PRIVDEF_BIT] && i_chk_req.priv);
			end
		end
		nxt_state.chk_valid = i_chk_valid;
		nxt_state.chk_resp.fault = i_chk_valid && fault;
		nxt_state.chk_resp.hit = hit;
		nxt_state.chk_resp.region = idx;
		nxt_state.chk_resp.attr = rac_decode(attr[RAC_ATTR_TEX_LSB +: 3], attr[RAC_ATTR_C_BIT],
			attr[RAC_ATTR_B_BIT], attr[RAC_ATTR_S_BIT]);
		nxt_state.mm_fault = i_chk_valid && fault;

		// cause capture, a new fault beats a simultaneous clear
		if (i_chk_valid && fault) begin
			setv[fetch ? RAC_CAUSE_FETCH_BIT : RAC_CAUSE_DATA_BIT] = 1'b1;
			if (!fetch) begin
				setv[RAC_CAUSE_ADDR_VALID_BIT] = 1'b1;
				if (!state_ff.cause[RAC_CAUSE_ADDR_VALID_BIT] ||
						clr[RAC_CAUSE_ADDR_VALID_BIT]) begin
					nxt_state.faddr = i_chk_req.addr;
				end
			end
		end
		nxt_state.cause = (state_ff.cause & ~clr) | setv;
	end

	// single state register
	always_ff @(posedge i_mclk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			state_ff <= '0;
			state_ff.awready <= 1'b1;
			state_ff.wready <= 1'b1;
			state_ff.arready <= 1'b1;
			state_ff.sel <= RAC_RST_SEL;
			state_ff.ctrl <= RAC_RST_WORD;
			state_ff.cause <= RAC_RST_WORD;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// outputs straight from the state register
	assign o_s_axi_awready = state_ff.awready;
	assign o_s_axi_wready = state_ff.wready;
	assign o_s_axi_bvalid = state_ff.bvalid;
	assign o_s_axi_bresp = state_ff.bresp;
	assign o_s_axi_arready = state_ff.arready;
	assign o_s_axi_rvalid = state_ff.rvalid;
	assign o_s_axi_rdata = state_ff.rdata;
	assign o_s_axi_rresp = state_ff.rresp;
	assign o_chk_valid = state_ff.chk_valid;
	assign o_chk_resp = state_ff.chk_resp;
	assign o_memory_management_fault = state_ff.mm_fault;

endmodule : rac_region_checker

// File: dv/rac_region_checker_properties.sv
module rac_region_checker_properties
	import rac_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_s_axi_awvalid,
	input wire logic o_s_axi_awready,
	input wire logic i_s_axi_wvalid,
	input wire logic o_s_axi_wready,
	input wire logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [1:0] o_s_axi_bresp,
	input wire logic i_s_axi_arvalid,
	input wire logic o_s_axi_arready,
	input wire logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	input wire logic [31:0] o_s_axi_rdata,
	input wire logic i_chk_valid,
	input wire logic o_chk_valid,
	input wire rac_resp_t o_chk_resp,
	input wire logic o_memory_management_fault
);
	timeunit 1ns;
	timeprecision 100ps;
	// single clock domain, async low reset
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	// check port answers exactly one cycle after each access
	chk_answer_a: assert property (i_chk_valid |=> o_chk_valid)
		else $error("check answer missing");
	chk_quiet_a: assert property (!i_chk_valid |=> !o_chk_valid)
		else $error("check answer without access");
	fault_pulse_a: assert property (o_memory_management_fault ==
		(o_chk_valid && o_chk_resp.fault))
		else $error("fault pulse differs from answer");
	fault_qual_a: assert property (o_chk_resp.fault |-> o_chk_valid)
		else $error("fault outside an answer");
	strong_share_a: assert property (o_chk_valid && o_chk_resp.attr.mem_type == RAC_MT_STRONG
		|-> o_chk_resp.attr.shareable)
		else $error("strongly ordered not shareable");
	reserved_share_a: assert property (o_chk_valid && o_chk_resp.attr.mem_type == RAC_MT_RESERVED
		|-> !o_chk_resp.attr.shareable)
		else $error("reserved encoding took the flag");
	// bus answers and their holding
	rd_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready
		|=> o_s_axi_rvalid && !o_s_axi_arready)
		else $error("read answer late");
	rd_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready
		|=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
		else $error("read data dropped");
	wr_answer_a: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid
		&& o_s_axi_wready |=> !o_s_axi_awready ##1 o_s_axi_bvalid)
		else $error("write answer late");
	wr_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready
		|=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
		else $error("write response dropped");
endmodule : rac_region_checker_properties

// File: dv/rac_core_model.sv
module rac_core_model
	import rac_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_resetn,
	output logic o_chk_valid,
	output rac_req_t o_chk_req
);
	timeunit 1ns;
	timeprecision 100ps;
	rac_req_t pend_q[$];
	// queue an access for the fetch or load/store path
	function automatic void send(input rac_req_t r);
		pend_q.push_back(r);
	endfunction : send
	// one access a cycle, back to back while work waits; idle address toggles
	always @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_chk_valid <= 1'b0;
			o_chk_req <= '0;
		end else if (pend_q.size() != 0) begin
			o_chk_valid <= 1'b1;
			o_chk_req <= pend_q.pop_front();
		end else begin
			o_chk_valid <= 1'b0;
			o_chk_req.addr <= ~o_chk_req.addr;
		end
	end
endmodule : rac_core_model

// File: dv/rac_region_checker_bench.sv
module rac_region_checker_bench
	import rac_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic fault;
		logic [3:0] region;
		logic cmp_pol;
		rac_attr_t attr;
	} rac_exp_t;
	logic i_mclk = 1'b0;
	logic i_resetn = 1'b0;
	logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic cv, rv, mmf;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	rac_req_t creq;
	rac_resp_t resp;
	int seed = 32'ha1f5d25a;
	int err_count = 0;
	int check_count = 0;
	rac_exp_t q_chk[$];
	logic [33:0] q_rd[$];
	logic [1:0] q_wr[$];
	rac_attr_t cur_attr;
	logic cur_cp;
	rac_exp_t ce;
	logic [33:0] re;
	rac_acc_kind_t k;

	always #2.5 i_mclk = ~i_mclk;

	rac_region_checker u_rac_region_checker (
		.i_mclk(i_mclk), .i_resetn(i_resetn),
		.i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr),
		.i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .i_s_axi_wdata(wdata),
		.i_s_axi_wstrb(4'hf), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
		.o_s_axi_bresp(bresp), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
		.i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
		.o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .i_chk_valid(cv), .i_chk_req(creq),
		.o_chk_valid(rv), .o_chk_resp(resp), .o_memory_management_fault(mmf)
	);
	rac_core_model u_rac_core_model (
		.i_mclk(i_mclk), .i_resetn(i_resetn), .o_chk_valid(cv), .o_chk_req(creq)
	);

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp

	task automatic end_sim;
		$display("errors %0d checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim

	// write address and data offered together, each released when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		bit aw_ok, w_ok;
		int n;
		aw_ok = 0;
		w_ok = 0;
		n = 0;
		q_wr.push_back(r);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		while (!(aw_ok && w_ok) && n < 100) begin
			@(posedge i_mclk);
			n++;
			if (!aw_ok && awready) begin
				aw_ok = 1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready) begin
				w_ok = 1;
				wvalid <= 1'b0;
			end
		end
		repeat ({$random(seed)} % 3) @(posedge i_mclk);
		bready <= 1'b1;
		do begin @(posedge i_mclk); n++; end while (!bvalid && n < 200);
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		n = 0;
		q_rd.push_back({r, d});
		arvalid <= 1'b1;
		araddr <= a;
		do begin @(posedge i_mclk); n++; end while (!arready && n < 100);
		arvalid <= 1'b0;
		repeat ({$random(seed)} % 3) @(posedge i_mclk);
		rready <= 1'b1;
		do begin @(posedge i_mclk); n++; end while (!rvalid && n < 200);
		rready <= 1'b0;
	endtask : axi_rd

	function automatic logic [31:0] attr_w(input logic xn, input logic [2:0] ap,
		input logic [2:0] type_extension_bits, input logic s, input logic c, input logic b, input logic [4:0] sz);
		return {3'h0, xn, 1'b0, ap, 2'h0, type_extension_bits, s, c, b, 10'h0, sz, 1'b1};
	endfunction : attr_w

	// permission table: fetch counts as read, never-execute blocks fetch
	function automatic logic exp_fault(input logic [2:0] ap, input logic xn, input logic p,
		input rac_acc_kind_t kd);
		logic rd, wr;
		rd = (ap == 3'h2 || ap == 3'h3 || ap >= 3'h6) || (p && (ap == 3'h1 || ap == 3'h5));
		wr = (ap == 3'h3) || (p && (ap == 3'h1 || ap == 3'h2));
		return (kd == RAC_ACC_WRITE) ? !wr : (!rd || (kd == RAC_ACC_FETCH && xn));
	endfunction : exp_fault

	task automatic chk(input logic [31:0] a, input logic p, input rac_acc_kind_t kd,
		input logic f, input logic [3:0] rg);
		q_chk.push_back('{f, rg, cur_cp, cur_attr});
		u_rac_core_model.send('{a, p, kd});
	endtask : chk

	task automatic wait_idle;
		int n;
		n = 0;
		while (q_chk.size() != 0 && n < 50) begin @(posedge i_mclk); n++; end
		cmp(32'(q_chk.size()), 32'h0, "check port idle");
	endtask : wait_idle

	task automatic mt(input logic [2:0] type_extension_bits, input logic c, input logic b, input logic s,
		input rac_mem_type_t t, input logic sh, input logic [3:0] pol, input logic cp);
		axi_wr(RAC_OFF_ATTR, attr_w(1'b0, RAC_AP_FULL, type_extension_bits, s, c, b, 5'd9), RAC_RESP_OKAY);
		cur_attr = '{t, sh, pol[3:2], pol[1:0]};
		cur_cp = cp;
		chk(32'h1000 | ({$random(seed)} & 32'h3ff), 1'b0, RAC_ACC_READ, 1'b0, 4'h1);
		wait_idle;
	endtask : mt

	// compare each answer with the oldest note
	always @(posedge i_mclk) begin
		if (bvalid && bready) cmp(32'(bresp), 32'(q_wr.pop_front()), "bresp");
		if (rvalid && rready) begin
			re = q_rd.pop_front();
			cmp(rdata, re[31:0], "rdata");
			cmp(32'(rresp), 32'(re[33:32]), "rresp");
		end
		if (rv) begin
			ce = q_chk.pop_front();
			cmp(32'(resp.fault), 32'(ce.fault), "fault");
			cmp(32'(mmf), 32'(ce.fault), "fault pulse");
			if (ce.region != 4'hf) begin
				cmp(32'({resp.hit, resp.region}), {27'h0, 1'b1, ce.region}, "region");
				cmp(32'(resp.attr & (ce.cmp_pol ? 8'hff : 8'hf0)),
					32'(ce.attr & (ce.cmp_pol ? 8'hff : 8'hf0)), "attributes");
			end
		end
	end

	initial begin
		#100000;
		err_count++;
		$display("ERROR %0t watchdog expired", $time);
		end_sim;
	end

	// main sequence
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		cur_attr = '{RAC_MT_NORMAL, 1'b0, 2'h2, 2'h2};
		cur_cp = 1'b1;
		repeat (12) @(posedge i_mclk);
		i_resetn <= 1'b1;
		repeat (3) @(posedge i_mclk);
		axi_rd(RAC_OFF_CTRL, 32'h0, RAC_RESP_OKAY);
		axi_rd(RAC_OFF_CAUSE, 32'h0, RAC_RESP_OKAY);
		axi_rd(8'h18, 32'h0, RAC_RESP_SLVERR);
		axi_wr(8'h18, 32'hffffffff, RAC_RESP_SLVERR);
		axi_wr(RAC_OFF_CTRL, 32'h1, RAC_RESP_OKAY);
		axi_wr(RAC_OFF_BASE, 32'h10, RAC_RESP_OKAY);
		axi_wr(RAC_OFF_ATTR, attr_w('0, RAC_AP_FULL, 3'h0, '0, '1, '0, 5'd31), RAC_RESP_OKAY);
		axi_wr(RAC_OFF_BASE, 32'h1011, RAC_RESP_OKAY);
		axi_rd(RAC_OFF_BASE, 32'h1001, RAC_RESP_OKAY);
		for (int ap = 0; ap < 8; ap++) begin
			axi_wr(RAC_OFF_ATTR, attr_w(ap[0], 3'(ap), 3'h0, '0, '1, '0, 5'd9), RAC_RESP_OKAY);
			for (int i = 0; i < 6; i++) begin
				k = rac_acc_kind_t'(i / 2);
				chk(32'h1000 | ({$random(seed)} & 32'h3ff), i[0], k,
					exp_fault(3'(ap), ap[0], i[0], k), 4'h1);
			end
			wait_idle;
		end
		axi_rd(RAC_OFF_ATTR, attr_w('1, 3'h7, 3'h0, '0, '1, '0, 5'd9), RAC_RESP_OKAY);
		chk(32'h13ff, 1'b0, RAC_ACC_READ, 1'b0, 4'h1);
		chk(32'h1400, 1'b0, RAC_ACC_WRITE, 1'b0, 4'h0);
		chk(32'h0ffc, 1'b0, RAC_ACC_WRITE, 1'b0, 4'h0);
		wait_idle;
		axi_wr(RAC_OFF_CAUSE, 32'h83, RAC_RESP_OKAY);
		chk(32'h1004, 1'b0, RAC_ACC_WRITE, 1'b1, 4'h1);
		wait_idle;
		axi_rd(RAC_OFF_CAUSE, 32'h82, RAC_RESP_OKAY);
		axi_rd(RAC_OFF_FADDR, 32'h1004, RAC_RESP_OKAY);
		axi_wr(RAC_OFF_CAUSE, 32'h83, RAC_RESP_OKAY);
		chk(32'h1008, 1'b1, RAC_ACC_FETCH, 1'b1, 4'h1);
		wait_idle;
		axi_rd(RAC_OFF_CAUSE, 32'h01, RAC_RESP_OKAY);
		mt(3'b000, '0, '0, '0, RAC_MT_STRONG, '1, 4'h0, '0);
		mt(3'b000, '0, '1, '0, RAC_MT_DEVICE, '1, 4'h0, '0);
		mt(3'b000, '1, '0, '0, RAC_MT_NORMAL, '0, 4'ha, '1);
		mt(3'b000, '1, '1, '1, RAC_MT_NORMAL, '1, 4'hf, '1);
		mt(3'b001, '0, '0, '1, RAC_MT_NORMAL, '1, 4'h0, '1);
		mt(3'b001, '0, '1, '1, RAC_MT_RESERVED, '0, 4'h0, '0);
		mt(3'b001, '1, '0, '1, RAC_MT_IMPDEF, '0, 4'h0, '0);
		mt(3'b001, '1, '1, '0, RAC_MT_NORMAL, '0, 4'h5, '1);
		mt(3'b010, '0, '0, '1, RAC_MT_DEVICE, '0, 4'h0, '0);
		mt(3'b010, '1, '0, '0, RAC_MT_RESERVED, '0, 4'h0, '0);
		mt(3'b110, '0, '1, '1, RAC_MT_NORMAL, '1, 4'h6, '1);
		mt(3'b111, '1, '0, '0, RAC_MT_NORMAL, '0, 4'hb, '1);
		mt(3'b100, '0, '0, '0, RAC_MT_NORMAL, '0, 4'h0, '1);
		// 32-byte region inside region 0: its last byte and the byte past it
		cur_attr = '{RAC_MT_NORMAL, 1'b0, 2'h2, 2'h2};
		axi_wr(RAC_OFF_ATTR, attr_w('0, RAC_AP_NONE, 3'h0, '0, '1, '0, 5'd4), RAC_RESP_OKAY);
		chk(32'h101f, 1'b1, RAC_ACC_READ, 1'b1, 4'h1);
		chk(32'h1020, 1'b0, RAC_ACC_WRITE, 1'b0, 4'h0);
		wait_idle;
		// region 0 off, privileged default map on: a miss faults only unprivileged
		axi_wr(RAC_OFF_BASE, 32'h10, RAC_RESP_OKAY);
		axi_wr(RAC_OFF_ATTR, 32'h0, RAC_RESP_OKAY);
		axi_wr(RAC_OFF_CTRL, 32'h5, RAC_RESP_OKAY);
		chk(32'h8000, 1'b1, RAC_ACC_WRITE, 1'b0, 4'hf);
		chk(32'h8000, 1'b0, RAC_ACC_READ, 1'b1, 4'hf);
		wait_idle;
		axi_wr(RAC_OFF_CTRL, 32'h0, RAC_RESP_OKAY);
		chk(32'h1000, 1'b0, RAC_ACC_WRITE, 1'b0, 4'hf);
		wait_idle;
		cmp(32'(q_wr.size() + q_rd.size()), 32'h0, "bus answers outstanding");
		end_sim;
	end
endmodule : rac_region_checker_bench

bind rac_region_checker rac_region_checker_properties u_rac_region_checker_properties (
	.i_mclk(i_mclk), .i_resetn(i_resetn), .i_s_axi_awvalid(i_s_axi_awvalid),
	.o_s_axi_awready(o_s_axi_awready), .i_s_axi_wvalid(i_s_axi_wvalid),
	.o_s_axi_wready(o_s_axi_wready), .o_s_axi_bvalid(o_s_axi_bvalid),
	.i_s_axi_bready(i_s_axi_bready), .o_s_axi_bresp(o_s_axi_bresp),
	.i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
	.o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready),
	.o_s_axi_rdata(o_s_axi_rdata), .i_chk_valid(i_chk_valid), .o_chk_valid(o_chk_valid),
	.o_chk_resp(o_chk_resp), .o_memory_management_fault(o_memory_management_fault)
);
